//--- rtl/embram_pkg.sv
// Shared constants for the embedded RAM block: geometry of the dedicated
// and small memories, small-block mode codes and reset values.
// Assumes nothing of its surroundings; compiled before every design file.
package embram_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Dedicated (medium) block: 512 words of two 9-bit byte lanes
    localparam int DED_AW     = 9;
    localparam int DED_DEPTH  = 512;
    localparam int LANE_W     = 9;
    localparam int DED_LANES  = 2;
    localparam int DED_W      = 18;
    localparam int NARROW_AW  = 10;
    localparam int PACK_AW    = 8;

    ////////////////////////////////////////////////////////////////////////
    // Small logic-cell block: ten cells of 16 x 2, two 10-bit lanes
    localparam int SML_AW     = 4;
    localparam int SML_CELLS  = 10;
    localparam int CELL_W     = 2;
    localparam int CELL_BITS  = 64;
    localparam int SML_W      = 20;
    localparam int SML_LANE_W = 10;
    localparam int SML_LANES  = 2;
    localparam int CELLS_PER_LANE = 5;
    localparam int ROM_AW     = 6;

    ////////////////////////////////////////////////////////////////////////
    // Small-block operating modes
    localparam logic [1:0] SML_MODE_RAM   = 2'h0;  // 16 x 20 dual-port RAM
    localparam logic [1:0] SML_MODE_ROM64 = 2'h1;  // 64 x 10 ROM
    localparam logic [1:0] SML_MODE_ROM32 = 2'h2;  // 32 x 20 ROM

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [DED_W-1:0] DED_Q_RST = 18'h00000;
    localparam logic [SML_W-1:0] SML_Q_RST = 20'h00000;

endpackage

//--- rtl/embram_cell.sv
// One adaptive logic cell used as memory: a 64-bit store that reads as
// 16 x 2 in RAM mode, 64 x 1 or 32 x 2 in ROM mode; writes on falling edges.
// Assumes the caller gates i_we with mode and lane enables.
`timescale 1ns/10ps
`default_nettype none
module embram_cell #(
    parameter logic [63:0] ROM_INIT = 64'h0
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Write side
    input  wire logic       i_we,
    input  wire logic [3:0] i_waddr,
    input  wire logic [1:0] i_wdata,
    // Read side
    input  wire logic [1:0] i_mode,
    input  wire logic [5:0] i_raddr,
    output logic      [1:0] o_rd
);

    logic [63:0] store;
    logic [63:0] next_store;

    ////////////////////////////////////////////////////////////////////////
    // Next contents: reset reloads the ROM image, a RAM write replaces a pair
    always_comb begin
        next_store = store;
        if (i_rst) begin
            next_store = ROM_INIT;
        end else if (i_we && i_mode == embram_pkg::SML_MODE_RAM) begin
            next_store[{i_waddr, 1'b0} +: 2] = i_wdata;
        end
    end

    // Store is clocked on the falling edge, half a cycle after capture
    always_ff @(negedge i_clk) begin
        store <= next_store;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux per mode, flow-through
    always_comb begin
        case (i_mode)
            embram_pkg::SML_MODE_ROM64: o_rd = {1'b0, store[i_raddr]};
            embram_pkg::SML_MODE_ROM32: o_rd = store[{i_raddr[4:0], 1'b0} +: 2];
            default:                    o_rd = store[{i_raddr[3:0], 1'b0} +: 2];
        endcase
    end

    a_cell_fall_write: assert property (@(negedge i_clk) disable iff (i_rst)
        (i_we && i_mode == embram_pkg::SML_MODE_RAM)
        |=> store[{$past(i_waddr), 1'b0} +: 2] == $past(i_wdata))
        else $error("cell write on falling edge lost");

endmodule // embram_cell
`default_nettype wire

//--- rtl/embram_port.sv
// Address register with hold, plus default handling of byte enables,
// for one memory port. Outputs are the effective values for this edge.
// Assumes inputs synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module embram_port #(
    parameter int AW       = 9,
    parameter int BEW      = 2,
    parameter bit USE_BE   = 1'b1,
    parameter bit USE_HOLD = 1'b1
) (
    // Clock and reset
    input  wire logic           i_clk,
    input  wire logic           i_rst,
    // User side
    input  wire logic [AW-1:0]  i_addr,
    input  wire logic           i_hold,
    input  wire logic [BEW-1:0] i_be,
    // Effective values
    output logic      [AW-1:0]  o_addr,
    output logic      [BEW-1:0] o_be
);

    logic [AW-1:0] addr_q;
    logic [AW-1:0] next_addr_q;
    logic          hold_eff;

    ////////////////////////////////////////////////////////////////////////
    // Unused hold reads as low, unused byte enables as all ones
    always_comb begin
        hold_eff    = USE_HOLD && i_hold;
        o_be        = USE_BE ? i_be : {BEW{1'b1}};
        o_addr      = i_rst ? '0 : (hold_eff ? addr_q : i_addr);
        next_addr_q = o_addr;
    end

    always_ff @(posedge i_clk) begin
        addr_q <= next_addr_q;
    end

    a_hold_keeps_addr: assert property (@(posedge i_clk) disable iff (i_rst)
        hold_eff |-> o_addr == $past(o_addr))
        else $error("held address moved");

    a_free_follows: assert property (@(posedge i_clk) disable iff (i_rst)
        !hold_eff |-> o_addr == i_addr)
        else $error("address ignored without hold");

endmodule // embram_port
`default_nettype wire

//--- rtl/embram_top.sv
// Embedded RAM block: a dedicated true dual-port medium memory with byte
// lanes, packed mode, mixed width and output clears, and a small memory
// built from ten logic cells (RAM or ROM). User fabric drives all ports.
// Assumes all inputs synchronous to i_clk; clears may arrive at any time.
`timescale 1ns/10ps
`default_nettype none
module embram_top #(
    parameter bit           USE_BE         = 1'b1,
    parameter bit           USE_HOLD       = 1'b1,
    parameter bit           DED_NEW_DATA   = 1'b1,
    parameter bit           DED_MASKED_OLD = 1'b1,
    parameter bit           DED_OUT_REG    = 1'b0,
    parameter bit           SML_OUT_REG    = 1'b1,
    parameter bit           DED_A_ACLR     = 1'b1,
    parameter bit           DED_B_ACLR     = 1'b1,
    parameter bit           SML_ACLR       = 1'b1,
    parameter logic [639:0] SML_ROM_INIT   = '0
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Dedicated block, common
    input  wire logic        i_packed,
    input  wire logic        i_ded_aclr,
    // Dedicated block, port A (x18)
    input  wire logic [8:0]  i_a_addr,
    input  wire logic [17:0] i_a_data,
    input  wire logic        i_a_we,
    input  wire logic [1:0]  i_a_be,
    input  wire logic        i_a_hold,
    output logic      [17:0] o_a_q,
    // Dedicated block, port B (x18 or x9)
    input  wire logic [9:0]  i_b_addr,
    input  wire logic [17:0] i_b_data,
    input  wire logic        i_b_we,
    input  wire logic [1:0]  i_b_be,
    input  wire logic        i_b_hold,
    input  wire logic        i_b_narrow,
    output logic      [17:0] o_b_q,
    // Small block, write port
    input  wire logic [3:0]  i_s_waddr,
    input  wire logic [19:0] i_s_wdata,
    input  wire logic        i_s_we,
    input  wire logic [1:0]  i_s_be,
    input  wire logic        i_s_whold,
    // Small block, read port
    input  wire logic [5:0]  i_s_raddr,
    input  wire logic        i_s_rhold,
    input  wire logic [1:0]  i_s_mode,
    input  wire logic        i_s_aclr,
    output logic      [19:0] o_s_q
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [17:0] ded_mem [embram_pkg::DED_DEPTH];
    logic [8:0]  a_addr_eff;
    logic [1:0]  a_be_eff;
    logic [9:0]  b_addr_eff;
    logic [1:0]  b_be_eff;
    logic [8:0]  a_word;
    logic [8:0]  b_word;
    logic        b_narrow_eff;
    logic [17:0] a_old;
    logic [17:0] b_old;
    logic [1:0]  a_wmask;
    logic [1:0]  b_wmask;
    logic [17:0] b_wdata;
    logic [17:0] a_q1;
    logic [17:0] a_q2;
    logic [17:0] b_q1;
    logic [17:0] b_q2;
    logic [17:0] next_a_q1;
    logic [17:0] next_b_q1;
    logic        a_clr;
    logic        b_clr;
    logic [3:0]  s_wa_eff;
    logic [1:0]  s_be_eff;
    logic [5:0]  s_ra_eff;
    logic [3:0]  s_wa_q;
    logic [19:0] s_wd_q;
    logic        s_we_q;
    logic [1:0]  s_be_q;
    logic [3:0]  next_s_wa_q;
    logic [19:0] next_s_wd_q;
    logic        next_s_we_q;
    logic [1:0]  next_s_be_q;
    logic [9:0]  cell_we;
    logic [1:0]  cell_rd [embram_pkg::SML_CELLS];
    logic [19:0] s_q1;
    logic [19:0] s_q2;
    logic [19:0] next_s_q1;
    logic        s_clr;

    // Output of one lane during a read or write, per build options
    function automatic logic [8:0] lane_out(input logic [8:0] old_v, input logic [8:0] new_v,
                                            input logic we, input logic en);
        if (we && en) begin
            return DED_NEW_DATA ? new_v : old_v;
        end else if (we) begin
            return DED_MASKED_OLD ? old_v : 9'h000;
        end
        return old_v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address hold and byte-enable defaults, one instance per port
    embram_port #(.AW(9), .BEW(2), .USE_BE(USE_BE), .USE_HOLD(USE_HOLD)) u_port_a (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_addr (i_a_addr),
        .i_hold (i_a_hold),
        .i_be   (i_a_be),
        .o_addr (a_addr_eff),
        .o_be   (a_be_eff)
    );

    embram_port #(.AW(10), .BEW(2), .USE_BE(USE_BE), .USE_HOLD(USE_HOLD)) u_port_b (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_addr (i_b_addr),
        .i_hold (i_b_hold),
        .i_be   (i_b_be),
        .o_addr (b_addr_eff),
        .o_be   (b_be_eff)
    );

    ////////////////////////////////////////////////////////////////////////
    // Dedicated block address mapping and write lanes
    always_comb begin
        b_narrow_eff = i_b_narrow && !i_packed;   // Packed halves are always x18
        if (i_packed) begin
            a_word = {1'b0, a_addr_eff[embram_pkg::PACK_AW-1:0]};
            b_word = {1'b1, b_addr_eff[embram_pkg::PACK_AW-1:0]};
        end else if (b_narrow_eff) begin
            a_word = a_addr_eff;
            b_word = b_addr_eff[9:1];
        end else begin
            a_word = a_addr_eff;
            b_word = b_addr_eff[8:0];
        end
        a_old   = ded_mem[a_word];
        b_old   = ded_mem[b_word];
        a_wmask = {2{i_a_we}} & a_be_eff;
        if (b_narrow_eff) begin
            b_wmask = b_addr_eff[0] ? {i_b_we & b_be_eff[0], 1'b0} : {1'b0, i_b_we & b_be_eff[0]};
            b_wdata = {2{i_b_data[8:0]}};
        end else begin
            b_wmask = {2{i_b_we}} & b_be_eff;
            b_wdata = i_b_data;
        end
    end

    // Array write on the rising edge, nine bits per lane stored as given;
    // B is applied after A so B wins a same-lane collision
    always_ff @(posedge i_clk) begin
        for (int l = 0; l < embram_pkg::DED_LANES; l++) begin
            if (a_wmask[l]) begin
                ded_mem[a_word][l*embram_pkg::LANE_W +: embram_pkg::LANE_W]
                    <= i_a_data[l*embram_pkg::LANE_W +: embram_pkg::LANE_W];
            end
            if (b_wmask[l]) begin
                ded_mem[b_word][l*embram_pkg::LANE_W +: embram_pkg::LANE_W]
                    <= b_wdata[l*embram_pkg::LANE_W +: embram_pkg::LANE_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dedicated read path: latch stage, then optional output register
    always_comb begin
        a_clr = i_ded_aclr && DED_A_ACLR;
        b_clr = i_ded_aclr && DED_B_ACLR;
        for (int l = 0; l < embram_pkg::DED_LANES; l++) begin
            next_a_q1[l*9 +: 9] = lane_out(a_old[l*9 +: 9], i_a_data[l*9 +: 9], i_a_we, a_be_eff[l]);
        end
        if (b_narrow_eff) begin
            next_b_q1 = {9'h000, lane_out(b_addr_eff[0] ? b_old[17:9] : b_old[8:0],
                                          i_b_data[8:0], i_b_we, b_be_eff[0])};
        end else begin
            next_b_q1[8:0]  = lane_out(b_old[8:0], b_wdata[8:0], i_b_we, b_be_eff[0]);
            next_b_q1[17:9] = lane_out(b_old[17:9], b_wdata[17:9], i_b_we, b_be_eff[1]);
        end
    end

    // Both stages clear asynchronously, so bypassed registers still zero q
    always_ff @(posedge i_clk or posedge a_clr) begin
        if (a_clr) begin
            a_q1 <= embram_pkg::DED_Q_RST;
            a_q2 <= embram_pkg::DED_Q_RST;
        end else if (i_rst) begin
            a_q1 <= embram_pkg::DED_Q_RST;
            a_q2 <= embram_pkg::DED_Q_RST;
        end else begin
            a_q1 <= next_a_q1;
            a_q2 <= a_q1;
        end
    end

    always_ff @(posedge i_clk or posedge b_clr) begin
        if (b_clr) begin
            b_q1 <= embram_pkg::DED_Q_RST;
            b_q2 <= embram_pkg::DED_Q_RST;
        end else if (i_rst) begin
            b_q1 <= embram_pkg::DED_Q_RST;
            b_q2 <= embram_pkg::DED_Q_RST;
        end else begin
            b_q1 <= next_b_q1;
            b_q2 <= b_q1;
        end
    end

    // Build-time selection only; both sources are flip-flops
    assign o_a_q = DED_OUT_REG ? a_q2 : a_q1;
    assign o_b_q = DED_OUT_REG ? b_q2 : b_q1;

    ////////////////////////////////////////////////////////////////////////
    // Small block: write and read address ports, each with its own hold
    embram_port #(.AW(4), .BEW(2), .USE_BE(USE_BE), .USE_HOLD(USE_HOLD)) u_port_sw (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_addr (i_s_waddr),
        .i_hold (i_s_whold),
        .i_be   (i_s_be),
        .o_addr (s_wa_eff),
        .o_be   (s_be_eff)
    );

    embram_port #(.AW(6), .BEW(1), .USE_BE(1'b0), .USE_HOLD(USE_HOLD)) u_port_sr (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_addr (i_s_raddr),
        .i_hold (i_s_rhold),
        .i_be   (1'b1),
        .o_addr (s_ra_eff),
        .o_be   ()
    );

    // Write capture on the rising edge; the cells commit on the falling one
    always_comb begin
        next_s_wa_q = s_wa_eff;
        next_s_wd_q = i_s_wdata;
        next_s_be_q = s_be_eff;
        next_s_we_q = i_s_we && !i_rst;
    end

    // Data captures carry no clear; the enable capture is cleared only through i_rst
    always_ff @(posedge i_clk) begin
        s_wa_q <= next_s_wa_q;
        s_wd_q <= next_s_wd_q;
        s_be_q <= next_s_be_q;
        s_we_q <= next_s_we_q;
    end

    // Byte masking by gating each lane's five cells; costs a gate per cell
    always_comb begin
        for (int c = 0; c < embram_pkg::SML_CELLS; c++) begin
            cell_we[c] = s_we_q && s_be_q[c / embram_pkg::CELLS_PER_LANE]
                         && (i_s_mode == embram_pkg::SML_MODE_RAM);
        end
    end

    // Ten cells on one shared write and read address
    for (genvar c = 0; c < embram_pkg::SML_CELLS; c++) begin : g_cell
        embram_cell #(.ROM_INIT(SML_ROM_INIT[c*embram_pkg::CELL_BITS +: embram_pkg::CELL_BITS])) u_cell (
            .i_clk   (i_clk),
            .i_rst   (i_rst),
            .i_we    (cell_we[c]),
            .i_waddr (s_wa_q),
            .i_wdata (s_wd_q[c*embram_pkg::CELL_W +: embram_pkg::CELL_W]),
            .i_mode  (i_s_mode),
            .i_raddr (s_ra_eff),
            .o_rd    (cell_rd[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Small read path: equal read and write widths only, no mixed FIFO
    always_comb begin
        s_clr = i_s_aclr && SML_ACLR;
        for (int c = 0; c < embram_pkg::SML_CELLS; c++) begin
            next_s_q1[c*2 +: 2] = cell_rd[c];
        end
        if (i_s_mode == embram_pkg::SML_MODE_ROM64) begin
            next_s_q1 = '0;
            for (int c = 0; c < embram_pkg::SML_CELLS; c++) begin
                next_s_q1[c] = cell_rd[c][0];
            end
        end
    end

    // Read stage has no latch and therefore no clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q1 <= embram_pkg::SML_Q_RST;
        end else begin
            s_q1 <= next_s_q1;
        end
    end

    always_ff @(posedge i_clk or posedge s_clr) begin
        if (s_clr) begin
            s_q2 <= embram_pkg::SML_Q_RST;
        end else if (i_rst) begin
            s_q2 <= embram_pkg::SML_Q_RST;
        end else begin
            s_q2 <= s_q1;
        end
    end

    assign o_s_q = SML_OUT_REG ? s_q2 : s_q1;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_a_full_write;
        i_a_we && a_be_eff == 2'h3 && !a_clr;
    endsequence

    sequence s_a_low_write;
        i_a_we && a_be_eff == 2'h1 && !(b_wmask != 2'h0 && b_word == a_word);  // B wins any lane
    endsequence

    a_packed_split: assert property (i_packed |-> !a_word[8] && b_word[8])
        else $error("packed halves overlap");

    a_masked_kept: assert property (s_a_low_write |=> ded_mem[$past(a_word)][17:9] == $past(a_old[17:9]))
        else $error("masked byte changed");

    a_low_lane_written: assert property (s_a_low_write |=> ded_mem[$past(a_word)][8:0] == $past(i_a_data[8:0]))
        else $error("enabled low byte not written");

    a_new_data_out: assert property (s_a_full_write ##1 !a_clr |-> !DED_NEW_DATA || a_q1 == $past(i_a_data))
        else $error("write output not new data");

    a_latch_clear: assert property (a_clr |-> o_a_q == 18'h00000 && a_q1 == 18'h00000)
        else $error("latch clear did not zero port A");

    a_narrow_upper: assert property (b_narrow_eff && !b_clr |=> b_q1[17:9] == 9'h000)
        else $error("narrow read upper bits not zero");

    a_small_reg_clear: assert property (s_clr |-> s_q2 == 20'h00000)
        else $error("small output register not cleared");

    a_small_mask: assert property (s_we_q && !s_be_q[1] |-> cell_we[9:5] == 5'h00)
        else $error("masked small lane written");

endmodule // embram_top
`default_nettype wire

//--- verif/embram_fabric.sv
// Fabric-side model of the user logic that drives the output clears.
// Assumes the bench raises i_clr between clock edges.
`timescale 1ns/10ps
`default_nettype none
module embram_fabric (
    // Request from the bench
    input  wire logic i_clr,
    // Clears toward the RAM block
    output logic      o_ded_aclr,
    output logic      o_s_aclr
);
    // Plain levels, no register: the clear must act without a clock edge
    always_comb begin
        o_ded_aclr = i_clr;
        o_s_aclr   = i_clr;
    end
endmodule // embram_fabric
`default_nettype wire

//--- verif/test_embram_top.sv
// Self-checking bench for the embedded RAM block, default parameters.
// Assumes the output registers are bypassed on the dedicated side.
`timescale 1ns/10ps
`default_nettype none
module test_embram_top;
    logic        i_clk, i_rst, i_packed, clr, ded_aclr, s_aclr;
    logic        a_we, a_hold, b_we, b_hold, b_narrow, s_we, s_whold, s_rhold;
    logic [1:0]  a_be, b_be, s_be, s_mode;
    logic [8:0]  a_addr;
    logic [9:0]  b_addr;
    logic [17:0] a_data, b_data, a_q, b_q;
    logic [3:0]  s_waddr;
    logic [5:0]  s_raddr;
    logic [19:0] s_wdata, s_q;
    int          err_count, compares;
    ////////////////////////////////////////////////////////////////////////
    embram_fabric embram_fabric_inst (.i_clr(clr), .o_ded_aclr(ded_aclr), .o_s_aclr(s_aclr));
    embram_top embram_top_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_packed(i_packed), .i_ded_aclr(ded_aclr),
        .i_a_addr(a_addr), .i_a_data(a_data), .i_a_we(a_we), .i_a_be(a_be),
        .i_a_hold(a_hold), .o_a_q(a_q), .i_b_addr(b_addr), .i_b_data(b_data),
        .i_b_we(b_we), .i_b_be(b_be), .i_b_hold(b_hold), .i_b_narrow(b_narrow),
        .o_b_q(b_q), .i_s_waddr(s_waddr), .i_s_wdata(s_wdata), .i_s_we(s_we),
        .i_s_be(s_be), .i_s_whold(s_whold), .i_s_raddr(s_raddr), .i_s_rhold(s_rhold),
        .i_s_mode(s_mode), .i_s_aclr(s_aclr), .o_s_q(s_q));
    ////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // Compare and count
    task automatic check(input string n, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Inputs move 1 ns after the edge so no race with the design
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask
    // One port A cycle; output is settled after the edge
    task automatic a_acc(input logic [8:0] ad, input logic [17:0] d, input logic w, input logic [1:0] be);
        a_addr = ad;
        a_data = d;
        a_we = w;
        a_be = be;
        tick();
        a_we = 1'b0;
    endtask
    // One port B cycle
    task automatic b_acc(input logic [9:0] ad, input logic [17:0] d, input logic w);
        b_addr = ad;
        b_data = d;
        b_we = w;
        tick();
        b_we = 1'b0;
    endtask
    // Small block write, taken on the rising edge
    task automatic s_wr(input logic [3:0] ad, input logic [19:0] d, input logic [1:0] be);
        s_waddr = ad;
        s_wdata = d;
        s_be = be;
        s_we = 1'b1;
        tick();
        s_we = 1'b0;
    endtask
    // Small block read: array stage then output register
    task automatic s_rd(input logic [5:0] ad);
        s_raddr = ad;
        tick();
        tick();
    endtask
    // Verdict, reached from the tests or the watchdog
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need well under 100 cycles
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    // Test sequence
    initial begin
        {i_packed, clr, a_we, a_hold, b_we, b_hold, b_narrow, s_we, s_whold, s_rhold} = '0;
        {a_addr, b_addr, a_data, b_data, s_waddr, s_raddr, s_wdata, s_mode} = '0;
        {a_be, b_be, s_be} = 6'h3F;
        err_count = 0;
        compares = 0;
        i_rst = 1'b1;
        repeat (10) tick();
        i_rst = 1'b0;
        check("a_q reset", {2'h0, a_q}, 20'h00000);
        // Lane masking keeps the masked byte, ninth bit stored as data
        a_acc(9'h005, 18'h3FFFF, 1'b1, 2'h3);
        a_acc(9'h005, 18'h0ABCD, 1'b1, 2'h1);
        check("a_q masked write", {2'h0, a_q}, 20'h3FFCD);
        a_acc(9'h005, 18'h00000, 1'b0, 2'h3);
        check("a_q lane0", {2'h0, a_q}, 20'h3FFCD);
        a_acc(9'h005, 18'h0ABCD, 1'b1, 2'h2);
        a_acc(9'h005, 18'h00000, 1'b0, 2'h3);
        check("a_q lane1", {2'h0, a_q}, 20'h0ABCD);
        $display("test lanes done");
        // Narrow port B reads each 9-bit lane
        b_narrow = 1'b1;
        b_acc(10'h00B, 18'h00000, 1'b0);
        check("b_q narrow hi", {2'h0, b_q}, 20'h00055);
        b_acc(10'h00A, 18'h00000, 1'b0);
        check("b_q narrow lo", {2'h0, b_q}, 20'h001CD);
        b_narrow = 1'b0;
        $display("test width done");
        // Address hold on A for read and write, B unaffected
        a_hold = 1'b1;
        a_acc(9'h006, 18'h00000, 1'b0, 2'h3);
        check("a_q hold read", {2'h0, a_q}, 20'h0ABCD);
        a_acc(9'h006, 18'h12345, 1'b1, 2'h3);
        b_acc(10'h005, 18'h00000, 1'b0);
        check("b_q own addr", {2'h0, b_q}, 20'h12345);
        a_hold = 1'b0;
        $display("test hold done");
        // Packed: B lands in the upper half
        i_packed = 1'b1;
        b_acc(10'h005, 18'h2AAAA, 1'b1);
        i_packed = 1'b0;
        a_acc(9'h105, 18'h00000, 1'b0, 2'h3);
        check("a_q packed", {2'h0, a_q}, 20'h2AAAA);
        $display("test packed done");
        // Small block: falling-edge write seen by the next read
        s_wr(4'h3, 20'hABCDE, 2'h3);
        s_wr(4'h3, 20'h12345, 2'h1);
        s_rd(6'h03);
        check("s_q masked", s_q, 20'hABF45);
        // Held read address keeps word 3 although 0 is presented
        s_rhold = 1'b1;
        s_rd(6'h00);
        check("s_q read hold", s_q, 20'hABF45);
        s_rhold = 1'b0;
        // ROM32 refuses a write; both ROM modes reread the same cells
        s_mode = 2'h2;
        s_wr(4'h3, 20'h00000, 2'h3);
        s_rd(6'h03);
        check("s_q rom32", s_q, 20'hABF45);
        s_mode = 2'h1;
        s_rd(6'h06);
        check("s_q rom64", s_q, 20'h0007B);
        s_mode = 2'h0;
        $display("test small done");
        // Clears act at once, no edge
        clr = 1'b1;
        #1;
        check("a_q clear", {2'h0, a_q}, 20'h00000);
        check("s_q clear", s_q, 20'h00000);
        // Keep the clear across an edge: outputs must stay zero
        tick();
        check("a_q clear held", {2'h0, a_q}, 20'h00000);
        check("s_q clear held", s_q, 20'h00000);
        clr = 1'b0;
        $display("test clear done");
        summarize();
    end
endmodule // test_embram_top
`default_nettype wire
